// [hdl/abg_cfg.svh]
// glue control constants: bit positions, reset values, timing
// assumes inclusion by bare name from design files
`ifndef ABG_CFG_SVH
`define ABG_CFG_SVH
`define ABG_SHARED_PIN_FUNCTION_SELECT_BIT 1
`define ABG_PORTB_GATE_BIT 0
`define ABG_PORTB_SPKEN_BIT 1
`define ABG_PORTA_A20_BIT 1
`define ABG_CLK_PERIOD_NS 100
`define ABG_SLOW_MAX_MHZ 8
`define ABG_TURBO_RST 1'b1
`define ABG_DIVSEL_RST 2'h0
`define ABG_DIVSEL_W 2
`endif

// [hdl/abg_pkg.sv]
// glue control types
// assumes nothing beyond a SystemVerilog compiler
package abg_pkg;
   typedef enum logic [1:0] {ABG_IDLE = 2'b00, ABG_LATCH = 2'b01, ABG_HOLD = 2'b11} abg_ale_e;
   typedef logic [1:0] abg_div_t;
endpackage : abg_pkg

// [hdl/abg_clk_if.sv]
// carrier between glue top and clock divider
// assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
interface abg_clk_if;
   logic slow_sel;
   logic use_osc;
   abg_pkg::abg_div_t div_sel;
   logic clk_en;
   modport ctl (output slow_sel, output use_osc, output div_sel, input clk_en);
   modport div (input slow_sel, input use_osc, input div_sel, output clk_en);
endinterface : abg_clk_if
`default_nettype wire

// [hdl/abg_clk_div.sv]
// system clock divider: divide by 2,4,6,8 of cpu clock or bus oscillator
// assumes the oscillator level arrives already synchronised
`timescale 1ns/1ns
`default_nettype none
`include "abg_cfg.svh"
module abg_clk_div (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic osc_sync_in,
   abg_clk_if.div cif
);
   logic [3:0] cnt_ff;
   logic osc_d_ff;
   logic [3:0] lim;
   logic tick;
   always_comb begin
      lim = {1'b0, cif.div_sel, 1'b0} + 4'h1;
   end
   assign tick = cif.use_osc ? (osc_sync_in & ~osc_d_ff) : 1'b1;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         osc_d_ff <= 1'b1;
      end else begin
         osc_d_ff <= osc_sync_in;
      end
   end
   // divider counts base ticks
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_ff <= 4'h0;
      end else if (tick) begin
         cnt_ff <= (cnt_ff >= lim) ? 4'h0 : cnt_ff + 4'h1;
      end
   end
   // full speed unless slow selected
   assign cif.clk_en = ~cif.slow_sel | (tick & (cnt_ff == 4'h0));
endmodule : abg_clk_div
`default_nettype wire

// [hdl/abg_glue_top.sv]
// at bus glue control top: speaker, three-state, turbo, a20, ale, clock select, dma requests
// assumes pins arrive asynchronously; only speaker, TURBO_IN, oscillator, sleep miss, hold acknowledge, master and DRQ_IN are synchronised here
`timescale 1ns/1ns
`default_nettype none
`include "abg_cfg.svh"
module abg_glue_top #(
   parameter int DRQ_W = 8
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic POWER_OK_IN,
   input wire logic SPEAKER_OR_THREESTATE_N_IN,
   output logic SPEAKER_OR_THREESTATE_N_OUT,
   output logic SPEAKER_OR_THREESTATE_N_OE_OUT,
   input wire logic TIMER2_IN,
   input wire logic [7:0] PORTB_IN,
   input wire logic [7:0] PORTA_IN,
   input wire logic [7:0] SLEEP_CONTROL_REG_IN,
   input wire logic SLEEP_MISS_N_IN,
   output logic SLEEP_REQ_OUT,
   output logic CACHE_MISS_OUT,
   input wire logic TURBO_IN,
   input wire logic SW_TURBO_IN,
   output logic TURBO_EFF_OUT,
   input wire logic HOLD_ACKNOWLEDGE_IN,
   input wire logic MASTER_N_IN,
   output logic AEN_OUT,
   input wire logic CYCLE_START_IN,
   input wire logic CYCLE_DRAM_IN,
   output logic BALE_OUT,
   output logic EARLY_LATCH_ENABLE_N_OUT,
   input wire logic ADDR20_GATE_INTERNAL_IN,
   output logic ADDR20_BLOCK_N_OUT,
   input wire logic BUS_OSCILLATOR_IN,
   input wire logic USE_OSC_IN,
   input wire logic [1:0] DIV_SEL_IN,
   output logic SYS_CLK_EN_OUT,
   input wire logic [DRQ_W-1:0] DRQ_IN,
   output logic [DRQ_W-1:0] DRQ_SYNC_OUT,
   output logic DRQ16_OUT,
   output logic THREESTATE_OUT
);
   abg_clk_if cif ();
   logic [1:0] spk_s_ff;
   logic [1:0] turbo_s_ff;
   logic [1:0] osc_s_ff;
   logic [1:0] slp_s_ff;
   logic [1:0] hold_acknowledge_s_ff;
   logic [1:0] mst_s_ff;
   logic [DRQ_W-1:0] drq_s1_ff;
   logic [DRQ_W-1:0] drq_s2_ff;
   logic tri_ff;
   logic spk_ff;
   logic bale_ff;
   logic early_latch_enable_n_ff;
   logic aen_ff;
   logic a20_ff;
   logic turbo_ff;
   abg_pkg::abg_ale_e ale_st_ff;
   abg_pkg::abg_ale_e nxt_ale_st;
   logic new_cycle;

   ////////////////////////////////////////////////////////////////////////
   // synchronisers
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         spk_s_ff <= 2'h3;
         turbo_s_ff <= 2'h3;
         osc_s_ff <= 2'h3;
         slp_s_ff <= 2'h3;
         hold_acknowledge_s_ff <= 2'h0;
         mst_s_ff <= 2'h3;
      end else begin
         spk_s_ff <= {spk_s_ff[0], SPEAKER_OR_THREESTATE_N_IN};
         turbo_s_ff <= {turbo_s_ff[0], TURBO_IN};
         osc_s_ff <= {osc_s_ff[0], BUS_OSCILLATOR_IN};
         slp_s_ff <= {slp_s_ff[0], SLEEP_MISS_N_IN};
         hold_acknowledge_s_ff <= {hold_acknowledge_s_ff[0], HOLD_ACKNOWLEDGE_IN};
         mst_s_ff <= {mst_s_ff[0], MASTER_N_IN};
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < DRQ_W; gi++) begin : g_drq
         always_ff @(posedge CLK_IN or posedge RST_IN) begin
            if (RST_IN) begin
               drq_s1_ff[gi] <= 1'b0;
               drq_s2_ff[gi] <= 1'b0;
            end else begin
               drq_s1_ff[gi] <= DRQ_IN[gi];
               drq_s2_ff[gi] <= (gi == 4) ? 1'b0 : drq_s1_ff[gi];
            end
         end
      end
   endgenerate
   assign DRQ_SYNC_OUT = drq_s2_ff;
   assign DRQ16_OUT = |drq_s2_ff[DRQ_W-1:5];

   ////////////////////////////////////////////////////////////////////////
   // three-state entry and speaker
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         tri_ff <= 1'b0;
      end else if (!POWER_OK_IN) begin
         tri_ff <= ~spk_s_ff[1];
      end
   end
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         spk_ff <= 1'b0;
      end else begin
         spk_ff <= TIMER2_IN & PORTB_IN[`ABG_PORTB_GATE_BIT] & PORTB_IN[`ABG_PORTB_SPKEN_BIT];
      end
   end
   assign THREESTATE_OUT = tri_ff;
   assign SPEAKER_OR_THREESTATE_N_OUT = spk_ff;
   assign SPEAKER_OR_THREESTATE_N_OE_OUT = POWER_OK_IN & ~tri_ff;

   ////////////////////////////////////////////////////////////////////////
   // shared pin function
   assign SLEEP_REQ_OUT = ~SLEEP_CONTROL_REG_IN[`ABG_SHARED_PIN_FUNCTION_SELECT_BIT] & ~slp_s_ff[1];
   assign CACHE_MISS_OUT = SLEEP_CONTROL_REG_IN[`ABG_SHARED_PIN_FUNCTION_SELECT_BIT] & ~slp_s_ff[1];

   ////////////////////////////////////////////////////////////////////////
   // turbo and clock selection
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         turbo_ff <= `ABG_TURBO_RST;
      end else begin
         turbo_ff <= turbo_s_ff[1] & SW_TURBO_IN;
      end
   end
   assign TURBO_EFF_OUT = turbo_ff;
   assign cif.slow_sel = ~turbo_ff;
   assign cif.use_osc = USE_OSC_IN;
   assign cif.div_sel = DIV_SEL_IN;
   assign SYS_CLK_EN_OUT = cif.clk_en & ~tri_ff;
   abg_clk_div u_div (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .osc_sync_in(osc_s_ff[1]),
      .cif(cif)
   );

   ////////////////////////////////////////////////////////////////////////
   // address enable and a20 block
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         aen_ff <= 1'b0;
         a20_ff <= 1'b0;
      end else begin
         aen_ff <= hold_acknowledge_s_ff[1] & mst_s_ff[1];
         a20_ff <= ADDR20_GATE_INTERNAL_IN | PORTA_IN[`ABG_PORTA_A20_BIT];
      end
   end
   assign AEN_OUT = aen_ff;
   assign ADDR20_BLOCK_N_OUT = a20_ff;

   ////////////////////////////////////////////////////////////////////////
   // address latch enables
   assign new_cycle = CYCLE_START_IN & ~CYCLE_DRAM_IN;
   always_comb begin
      nxt_ale_st = abg_pkg::ABG_IDLE;
      case (ale_st_ff)
         abg_pkg::ABG_IDLE: begin
            if (hold_acknowledge_s_ff[1]) begin
               nxt_ale_st = abg_pkg::ABG_HOLD;
            end else if (new_cycle) begin
               nxt_ale_st = abg_pkg::ABG_LATCH;
            end
         end
         abg_pkg::ABG_LATCH: begin
            nxt_ale_st = hold_acknowledge_s_ff[1] ? abg_pkg::ABG_HOLD : abg_pkg::ABG_IDLE;
         end
         abg_pkg::ABG_HOLD: begin
            nxt_ale_st = hold_acknowledge_s_ff[1] ? abg_pkg::ABG_HOLD : abg_pkg::ABG_IDLE;
         end
         default: begin
            nxt_ale_st = abg_pkg::ABG_IDLE;
         end
      endcase
   end
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ale_st_ff <= abg_pkg::ABG_IDLE;
      end else begin
         ale_st_ff <= nxt_ale_st;
      end
   end
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         bale_ff <= 1'b0;
         early_latch_enable_n_ff <= 1'b1;
      end else begin
         bale_ff <= (nxt_ale_st != abg_pkg::ABG_IDLE);
         early_latch_enable_n_ff <= (nxt_ale_st == abg_pkg::ABG_IDLE);
      end
   end
   assign BALE_OUT = bale_ff;
   assign EARLY_LATCH_ENABLE_N_OUT = early_latch_enable_n_ff;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   property p_aen;
      @(posedge CLK_IN) disable iff (RST_IN)
      (hold_acknowledge_s_ff[1] && mst_s_ff[1]) |=> AEN_OUT;
   endproperty
   a_aen: assert property (p_aen) else $error("aen not high");
   property p_aen_low;
      @(posedge CLK_IN) disable iff (RST_IN)
      !(hold_acknowledge_s_ff[1] && mst_s_ff[1]) |=> !AEN_OUT;
   endproperty
   a_aen_low: assert property (p_aen_low) else $error("aen not low");
   property p_bale_pulse;
      @(posedge CLK_IN) disable iff (RST_IN)
      (new_cycle && !hold_acknowledge_s_ff[1] && ale_st_ff == abg_pkg::ABG_IDLE)
         |=> BALE_OUT ##1 (!BALE_OUT || hold_acknowledge_s_ff[1]);
   endproperty
   a_bale_pulse: assert property (p_bale_pulse) else $error("bale pulse wrong");
   property p_bale_hold;
      @(posedge CLK_IN) disable iff (RST_IN)
      hold_acknowledge_s_ff[1] |=> BALE_OUT;
   endproperty
   a_bale_hold: assert property (p_bale_hold) else $error("bale not held");
   property p_early_pulse;
      @(posedge CLK_IN) disable iff (RST_IN)
      (new_cycle && !hold_acknowledge_s_ff[1] && ale_st_ff == abg_pkg::ABG_IDLE) |=> !EARLY_LATCH_ENABLE_N_OUT;
   endproperty
   a_early_pulse: assert property (p_early_pulse) else $error("early latch pulse missing");
   property p_early_end;
      @(posedge CLK_IN) disable iff (RST_IN)
      (ale_st_ff == abg_pkg::ABG_LATCH && !hold_acknowledge_s_ff[1]) |=> EARLY_LATCH_ENABLE_N_OUT;
   endproperty
   a_early_end: assert property (p_early_end) else $error("early latch pulse too long");
   property p_early_hold;
      @(posedge CLK_IN) disable iff (RST_IN)
      hold_acknowledge_s_ff[1] |=> !EARLY_LATCH_ENABLE_N_OUT;
   endproperty
   a_early_hold: assert property (p_early_hold) else $error("early latch not held low");
   property p_a20;
      @(posedge CLK_IN) disable iff (RST_IN)
      (!RST_IN && (ADDR20_GATE_INTERNAL_IN || PORTA_IN[1])) |=> ADDR20_BLOCK_N_OUT;
   endproperty
   a_a20: assert property (p_a20) else $error("a20 block wrong");
   property p_turbo;
      @(posedge CLK_IN) disable iff (RST_IN)
      (!RST_IN && !SW_TURBO_IN) |=> !TURBO_EFF_OUT;
   endproperty
   a_turbo: assert property (p_turbo) else $error("turbo not gated");
   property p_turbo_on;
      @(posedge CLK_IN) disable iff (RST_IN)
      (turbo_s_ff[1] && SW_TURBO_IN) |=> TURBO_EFF_OUT;
   endproperty
   a_turbo_on: assert property (p_turbo_on) else $error("turbo not selected");
   property p_fast_clk;
      @(posedge CLK_IN) disable iff (RST_IN)
      (TURBO_EFF_OUT && !THREESTATE_OUT) |-> SYS_CLK_EN_OUT;
   endproperty
   a_fast_clk: assert property (p_fast_clk) else $error("full speed clock missing");
   property p_drq_low;
      @(posedge CLK_IN) disable iff (RST_IN)
      (!DRQ_IN[0] ##1 !DRQ_IN[0]) |=> !DRQ_SYNC_OUT[0];
   endproperty
   a_drq_low: assert property (p_drq_low) else $error("request release latency");
   property p_speaker;
      @(posedge CLK_IN) disable iff (RST_IN)
      !PORTB_IN[1] |=> !SPEAKER_OR_THREESTATE_N_OUT;
   endproperty
   a_speaker: assert property (p_speaker) else $error("speaker not gated");
   property p_tri;
      @(posedge CLK_IN) disable iff (RST_IN)
      (!POWER_OK_IN && !spk_s_ff[1]) |=> (THREESTATE_OUT && !SPEAKER_OR_THREESTATE_N_OE_OUT);
   endproperty
   a_tri: assert property (p_tri) else $error("three-state not entered");
   property p_slpmiss;
      @(posedge CLK_IN) disable iff (RST_IN)
      !(SLEEP_REQ_OUT && CACHE_MISS_OUT);
   endproperty
   a_slpmiss: assert property (p_slpmiss) else $error("shared pin both functions");
   property p_drq4;
      @(posedge CLK_IN) disable iff (RST_IN)
      DRQ_IN[4] |-> ##2 !DRQ_SYNC_OUT[4];
   endproperty
   a_drq4: assert property (p_drq4) else $error("channel 4 request passed");
   property p_drq_sync;
      @(posedge CLK_IN) disable iff (RST_IN)
      (DRQ_IN[0] ##1 DRQ_IN[0]) |=> DRQ_SYNC_OUT[0];
   endproperty
   a_drq_sync: assert property (p_drq_sync) else $error("request sync latency");
endmodule : abg_glue_top
`default_nettype wire

// [dv/abg_cpu_model.sv]
// processor-side model: starts bus cycles, on board or not
// assumes the glue block's clock; drives on rising edges
`timescale 1ns/1ns
`default_nettype none
module abg_cpu_model (
   input wire logic clk_in,
   output logic start_out,
   output logic dram_out
);
   initial begin
      start_out = 1'b0;
      dram_out = 1'b0;
   end
   // one-cycle start; the qualifier is left inverted once released
   task automatic issue(input logic to_dram);
      @(posedge clk_in);
      start_out <= 1'b1;
      dram_out <= to_dram;
      @(posedge clk_in);
      start_out <= 1'b0;
      dram_out <= ~to_dram;
   endtask : issue
endmodule : abg_cpu_model
`default_nettype wire

// [dv/abg_glue_top_tb_top.sv]
// testbench for the glue control top
// assumes abg_cpu_model as the processor side
`timescale 1ns/1ns
`default_nettype none
module abg_glue_top_tb_top;
   logic clk = 1'b0, rst = 1'b1, pok = 1'b0, spk_drv = 1'b1, tmr = 1'b0, smn = 1'b1;
   logic turbo = 1'b1, swt = 1'b1, hold_ack = 1'b0, mst_n = 1'b1, a20g = 1'b0;
   logic osc = 1'b0, ocnt = 1'b0, osc_run = 1'b0, use_osc = 1'b0;
   logic [1:0] divs = 2'h0;
   logic [7:0] portb = 8'h00, porta = 8'h00, slp = 8'h00, drq = 8'h00, drq_s;
   logic spk_o, spk_oe, slp_req, cmiss, teff, aen, bale, early_n, blk_n, sclk_en, drq16, tri_o;
   logic start, dram;
   wire spk_pin = spk_oe ? spk_o : spk_drv;
   int n_errors = 0;
   int check_count = 0;
   abg_cpu_model cpu (.clk_in(clk), .start_out(start), .dram_out(dram));
   abg_glue_top #(.DRQ_W(8)) dut (.CLK_IN(clk), .RST_IN(rst), .POWER_OK_IN(pok),
      .SPEAKER_OR_THREESTATE_N_IN(spk_pin), .SPEAKER_OR_THREESTATE_N_OUT(spk_o),
      .SPEAKER_OR_THREESTATE_N_OE_OUT(spk_oe), .TIMER2_IN(tmr), .PORTB_IN(portb), .PORTA_IN(porta),
      .SLEEP_CONTROL_REG_IN(slp), .SLEEP_MISS_N_IN(smn), .SLEEP_REQ_OUT(slp_req), .CACHE_MISS_OUT(cmiss),
      .TURBO_IN(turbo), .SW_TURBO_IN(swt), .TURBO_EFF_OUT(teff), .HOLD_ACKNOWLEDGE_IN(hold_ack),
      .MASTER_N_IN(mst_n), .AEN_OUT(aen), .CYCLE_START_IN(start), .CYCLE_DRAM_IN(dram), .BALE_OUT(bale),
      .EARLY_LATCH_ENABLE_N_OUT(early_n), .ADDR20_GATE_INTERNAL_IN(a20g), .ADDR20_BLOCK_N_OUT(blk_n),
      .BUS_OSCILLATOR_IN(osc), .USE_OSC_IN(use_osc), .DIV_SEL_IN(divs), .SYS_CLK_EN_OUT(sclk_en),
      .DRQ_IN(drq), .DRQ_SYNC_OUT(drq_s), .DRQ16_OUT(drq16), .THREESTATE_OUT(tri_o));
   initial begin
      forever #50 clk = ~clk;
   end
   // bus oscillator: one rising edge every 4 clocks, still when not running
   always @(posedge clk) begin
      if (osc_run) begin
         ocnt <= ~ocnt;
         osc <= osc ^ ocnt;
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   task automatic cnt(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (sclk_en === 1'b1) c++;
      end
   endtask : cnt
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk("bale_rst", 8'h00, bale);
      chk("early_rst", 8'h01, early_n);
      chk("teff_rst", 8'h01, teff);
      chk("tri_rst", 8'h00, tri_o);
      chk("drq_rst", 8'h00, drq_s);
   endtask : t_reset
   task automatic t_spk;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         tmr <= i[0];
         portb <= {6'h00, i[2:1]};
         wt(4);
         chk("spk", i[0] & i[1] & i[2], spk_o);
         chk("spk_oe", 8'h01, spk_oe);
      end
   endtask : t_spk
   task automatic t_pin;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         slp <= {6'h00, i[0], 1'b0};
         smn <= i[1];
         wt(4);
         chk("sleep", {7'h00, ~i[1] & ~i[0]}, slp_req);
         chk("miss", {7'h00, ~i[1] & i[0]}, cmiss);
      end
   endtask : t_pin
   task automatic t_turbo;
      int c;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         turbo <= i[0];
         swt <= i[1];
         wt(5);
         chk("teff", i[0] & i[1], teff);
      end
      cnt(16, c);
      chk("fast", 8'h10, 8'(c));
   endtask : t_turbo
   task automatic t_div;
      int c;
      @(posedge clk);
      turbo <= 1'b0;
      for (int u = 0; u < 2; u++) begin
         for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            use_osc <= u[0];
            osc_run <= u[0];
            divs <= s[1:0];
            wt(40);
            cnt(u ? 192 : 48, c);
            chk("div", 8'(48 / (2 * s + 2)), 8'(c));
         end
      end
   endtask : t_div
   task automatic t_aen;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         hold_ack <= i[0];
         mst_n <= i[1];
         wt(5);
         chk("aen", i[0] & i[1], aen);
         if (i[0]) chk("bale_hold", 8'h01, bale);
         if (i[0]) chk("early_hold", 8'h00, early_n);
      end
      @(posedge clk);
      hold_ack <= 1'b0;
      wt(5);
   endtask : t_aen
   task automatic t_ale;
      for (int d = 0; d < 2; d++) begin
         cpu.issue(d[0]);
         #1;
         chk("bale", {7'h00, ~d[0]}, bale);
         chk("early", {7'h00, d[0]}, early_n);
         wt(1);
         chk("bale_end", 8'h00, bale);
         chk("early_end", 8'h01, early_n);
      end
      cpu.issue(1'b0);
      cpu.issue(1'b0);
      #1;
      chk("bale_b2b", 8'h01, bale);
      chk("early_b2b", 8'h00, early_n);
   endtask : t_ale
   task automatic t_a20;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         a20g <= i[0];
         porta <= {6'h00, i[1], 1'b0};
         wt(3);
         chk("addr20_block_n", i[0] | i[1], blk_n);
      end
   endtask : t_a20
   task automatic t_drq;
      logic [7:0] v[3] = '{8'hff, 8'h0f, 8'h40};
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         drq <= v[i];
         wt(5);
         chk("drq", v[i] & 8'hef, drq_s);
         chk("drq16", |v[i][7:5], drq16);
      end
   endtask : t_drq
   task automatic t_tri;
      @(posedge clk);
      pok <= 1'b0;
      spk_drv <= 1'b0;
      wt(5);
      chk("tri", 8'h01, tri_o);
      chk("tri_oe", 8'h00, spk_oe);
      chk("tri_clk", 8'h00, sclk_en);
      @(posedge clk);
      pok <= 1'b1;
      spk_drv <= 1'b1;
      wt(3);
      chk("tri_keep", 8'h01, tri_o);
      @(posedge clk);
      rst <= 1'b1;
      wt(2);
      @(posedge clk);
      rst <= 1'b0;
      wt(2);
      chk("tri_clear", 8'h00, tri_o);
   endtask : t_tri
   ////////////////////////////////////////////////////////////////
   initial begin
      wt(5);
      t_reset();
      @(posedge clk);
      rst <= 1'b0;
      pok <= 1'b1;
      wt(3);
      t_spk();
      t_pin();
      t_turbo();
      t_div();
      t_aen();
      t_ale();
      t_a20();
      t_drq();
      t_tri();
      test_done();
   end
   initial begin
      #1_000_000;
      n_errors++;
      test_done();
   end
endmodule : abg_glue_top_tb_top
`default_nettype wire
